// ### inc/port_a_pkg.sv
// Register map, field positions and reset values of the port A block
package port_a_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_DATA   = 8'h05;
    localparam logic [7:0] IDX_DIRECTION  = 8'h85;
    localparam logic [7:0] IDX_PULLUP_EN  = 8'h95;
    localparam logic [7:0] IDX_CHANGE_EN  = 8'h96;
    localparam logic [7:0] IDX_OPTION     = 8'h81;
    localparam logic [7:0] IDX_INT_CTRL   = 8'h0b;
    localparam logic [7:0] IDX_POWER_CTRL = 8'h8e;

    // Field positions
    localparam int OPT_PULLUP_OFF_BIT  = 7;
    localparam int INT_GLOBAL_EN_BIT   = 7;
    localparam int INT_CHANGE_EN_BIT   = 3;
    localparam int INT_CHANGE_FLAG_BIT = 0;
    localparam int PWR_WAKE_EN_BIT     = 5;
    localparam int INPUT_ONLY_PIN      = 3;

    // Implemented bits and crystal pin mask
    localparam logic [5:0] PULLUP_IMPL_MASK = 6'h37;
    localparam logic [5:0] CRYSTAL_PIN_MASK = 6'h30;
    localparam logic [7:0] INT_CTRL_MASK    = 8'h89;
    localparam logic [7:0] POWER_CTRL_MASK  = 8'h20;

    // Reset values
    localparam logic [5:0] RST_OUT_LATCH  = 6'h00;
    localparam logic [5:0] RST_DIRECTION  = 6'h3f;
    localparam logic [5:0] RST_PULLUP_EN  = 6'h37;
    localparam logic [5:0] RST_CHANGE_EN  = 6'h00;
    localparam logic [7:0] RST_OPTION     = 8'hff;
    localparam logic [7:0] RST_INT_CTRL   = 8'h00;
    localparam logic [7:0] RST_POWER_CTRL = 8'h00;
    localparam logic [5:0] RST_CMP_LATCH  = 6'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : port_a_pkg

// ### src/port_a_gpio.sv
// Six-pin port with pull-ups, change detection and low-power wake
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Pins other than three have a weak pull-up, each with its enable bit.
// RULE2 - A pin in output mode never has its pull-up on.
// RULE3 - Option bit 7 gates all pull-ups and resets to pull-ups off; here the pin three pull-up is not gated by it.
// RULE4 - Pin three pull-up follows the master clear selection, no register bit.
// RULE5 - Data register reads pin levels in bits 5-0, bits 7-6 read zero.
// RULE6 - Direction 1 makes an input, 0 drives the output latch; reset to 1.
// RULE7 - Direction bit of pin three is read-only and reads 1.
// RULE8 - In crystal modes bits 5:4 of direction, pull-up and change enables read 1.
// RULE9 - Pull-up enable bits 5,4,2,1,0 act; bit 3 and 7-6 read 0.
// RULE10 - Pull-up on only with its enable, input mode and global permission.
// RULE11 - Each pin has a change enable bit, cleared at power-on reset.
// RULE12 - Enabled pins compare against the read latch; any mismatch sets change flag.
// RULE13 - A port change condition wakes the device from sleep.
// RULE14 - Any data register access reloads the latch; software then clears flag.
// RULE15 - A lasting mismatch keeps setting the change flag over software clears.
// RULE16 - The compare latch survives warm resets; flag sets again on mismatch.
// RULE17 - A change during a port read may be missed; accepted.
// RULE18 - Power control bit 5 switches a current sink onto pin zero.
// RULE19 - Software charges pin zero, enables change, makes it input, then sleeps.
// RULE20 - Pin zero falling wakes the core; vector if global enable set.
// RULE21 - Change event interrupts only with global interrupt enable set.
// RULE22 - Mismatch is checked every cycle on registered pin samples.
module port_a_gpio #(
    parameter int ADDR_W = 10,
    parameter int PINS   = 6
) (
    input  wire logic              REF_CLK,
    input  wire logic              RESETN,
    input  wire logic              WARM_RESETN,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    input  wire logic [PINS-1:0]   PIN_IN,
    output logic [PINS-1:0]        PIN_OUT,
    output logic [PINS-1:0]        PIN_OE,
    output logic [PINS-1:0]        PULLUP_ON,
    output logic                   ULP_SINK_ON,
    input  wire logic              CLEAR_PIN_SELECT,
    input  wire logic              CRYSTAL_MODE,
    input  wire logic              SLEEP_ENTER,
    output logic                   SLEEPING,
    output logic                   WAKE,
    output logic                   WAKE_TO_VECTOR,
    output logic                   PORT_IRQ
);

    // Word index from a byte address
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    // Register is mapped and word aligned
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        is_mapped = (addr[1:0] == 2'b00) &&
                    (idx == port_a_pkg::IDX_PIN_DATA ||
                     idx == port_a_pkg::IDX_DIRECTION ||
                     idx == port_a_pkg::IDX_PULLUP_EN ||
                     idx == port_a_pkg::IDX_CHANGE_EN ||
                     idx == port_a_pkg::IDX_OPTION ||
                     idx == port_a_pkg::IDX_INT_CTRL ||
                     idx == port_a_pkg::IDX_POWER_CTRL);
    endfunction : is_mapped

    logic [PINS-1:0]   out_latch;
    logic [PINS-1:0]   direction;
    logic [PINS-1:0]   pullup_en;
    logic [PINS-1:0]   change_en;
    logic [7:0]        option;
    logic [7:0]        int_ctrl;
    logic [7:0]        power_ctrl;
    logic [PINS-1:0]   pin_sample;
    logic [PINS-1:0]   cmp_latch;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              aw_fire;
    logic              w_fire;
    logic              do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic [7:0]        wr_idx;
    logic              wr_ok;
    logic              ar_fire;
    logic [7:0]        rd_idx;
    logic [7:0]        rd_value;
    logic              port_access;
    logic [PINS-1:0]   crystal_bits;
    logic [PINS-1:0]   dir_eff;
    logic [PINS-1:0]   pullup_eff;
    logic [PINS-1:0]   change_eff;
    logic [PINS-1:0]   pin_levels;
    logic              mismatch;
    logic              change_flag;
    logic              next_flag;
    logic              wake_cond;

    // Channel handshakes and merged write request
    assign AWREADY  = !aw_full && !BVALID;
    assign WREADY   = !w_full && !BVALID;
    assign ARREADY  = !RVALID;
    assign aw_fire  = AWVALID && AWREADY;
    assign w_fire   = WVALID && WREADY;
    assign ar_fire  = ARVALID && ARREADY;
    assign do_write = (aw_full || aw_fire) && (w_full || w_fire);
    assign wr_addr  = aw_full ? aw_addr : AWADDR;
    assign wr_byte  = w_full ? w_data[7:0] : WDATA[7:0];
    assign wr_idx   = word_index(wr_addr);
    assign wr_ok    = do_write && is_mapped(wr_addr)
                      && (w_full ? w_lane0 : WSTRB[0]);
    assign rd_idx   = (ARADDR[1:0] == 2'b00) ? word_index(ARADDR) : 8'h00;

    // Write address and data holding, either order
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_lane0 <= 1'b0;
        end else if (do_write) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_full <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (w_fire) begin
                w_full  <= 1'b1;
                w_data  <= WDATA;
                w_lane0 <= WSTRB[0];
            end
        end
    end

    // Write response, error on unmapped index
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            BVALID <= 1'b0;
            BRESP  <= port_a_pkg::RESP_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            BRESP  <= is_mapped(wr_addr) ? port_a_pkg::RESP_OKAY
                                         : port_a_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Output latch, cleared by warm reset too
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            out_latch <= port_a_pkg::RST_OUT_LATCH;
        end else if (!WARM_RESETN) begin
            out_latch <= port_a_pkg::RST_OUT_LATCH;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_PIN_DATA) begin
            out_latch <= wr_byte[PINS-1:0];
        end
    end

    // RULE6 direction bits reset to input
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            direction <= port_a_pkg::RST_DIRECTION;
        end else if (!WARM_RESETN) begin
            direction <= port_a_pkg::RST_DIRECTION;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_DIRECTION) begin
            direction <= wr_byte[PINS-1:0];
        end
    end

    // RULE9 only implemented pull-up bits store
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pullup_en <= port_a_pkg::RST_PULLUP_EN;
        end else if (!WARM_RESETN) begin
            pullup_en <= port_a_pkg::RST_PULLUP_EN;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_PULLUP_EN) begin
            pullup_en <= wr_byte[PINS-1:0] & port_a_pkg::PULLUP_IMPL_MASK;
        end
    end

    // RULE11 change enables cleared at reset
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            change_en <= port_a_pkg::RST_CHANGE_EN;
        end else if (!WARM_RESETN) begin
            change_en <= port_a_pkg::RST_CHANGE_EN;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_CHANGE_EN) begin
            change_en <= wr_byte[PINS-1:0];
        end
    end

    // RULE3 option resets with pull-ups globally off
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            option <= port_a_pkg::RST_OPTION;
        end else if (!WARM_RESETN) begin
            option <= port_a_pkg::RST_OPTION;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_OPTION) begin
            option <= wr_byte;
        end
    end

    // Interrupt control enables; flag kept apart
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            int_ctrl <= port_a_pkg::RST_INT_CTRL;
        end else if (!WARM_RESETN) begin
            int_ctrl <= port_a_pkg::RST_INT_CTRL;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_INT_CTRL) begin
            int_ctrl <= wr_byte & port_a_pkg::INT_CTRL_MASK;
        end
    end

    // RULE18 wake enable in power control
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            power_ctrl <= port_a_pkg::RST_POWER_CTRL;
        end else if (!WARM_RESETN) begin
            power_ctrl <= port_a_pkg::RST_POWER_CTRL;
        end else if (wr_ok && wr_idx == port_a_pkg::IDX_POWER_CTRL) begin
            power_ctrl <= wr_byte & port_a_pkg::POWER_CTRL_MASK;
        end
    end

    // RULE22 pin samples taken every cycle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_sample <= '0;
        end else begin
            pin_sample <= PIN_IN;
        end
    end

    // RULE8 crystal pins forced to one
    assign crystal_bits = CRYSTAL_MODE ? port_a_pkg::CRYSTAL_PIN_MASK : '0;

    // RULE7 pin three always an input
    always_comb begin
        dir_eff = direction | crystal_bits;
        dir_eff[port_a_pkg::INPUT_ONLY_PIN] = 1'b1;
    end

    assign change_eff = change_en | crystal_bits;

    // RULE1 RULE2 RULE10 per-pin pull-up gating
    always_comb begin
        pullup_eff = (pullup_en | crystal_bits) & port_a_pkg::PULLUP_IMPL_MASK;
        // RULE3 global control gates all pins but three
        PULLUP_ON = pullup_eff & dir_eff
                    & {PINS{!option[port_a_pkg::OPT_PULLUP_OFF_BIT]}};
        // RULE4 pin three follows clear selection
        PULLUP_ON[port_a_pkg::INPUT_ONLY_PIN] = CLEAR_PIN_SELECT;
    end

    // RULE6 driver on when direction is zero
    assign PIN_OUT = out_latch;
    assign PIN_OE  = ~dir_eff;

    // RULE18 current sink onto pin zero
    assign ULP_SINK_ON = power_ctrl[port_a_pkg::PWR_WAKE_EN_BIT];

    // RULE5 pin levels; pin three zero as clear input
    always_comb begin
        pin_levels = pin_sample;
        if (CLEAR_PIN_SELECT) begin
            pin_levels[port_a_pkg::INPUT_ONLY_PIN] = 1'b0;
        end
    end

    // Read value mux; misaligned and unimplemented bits read zero
    always_comb begin
        rd_value = 8'h00;
        unique case (rd_idx)
            port_a_pkg::IDX_PIN_DATA:   rd_value = {2'b00, pin_levels};
            // RULE7 RULE8 direction readback
            port_a_pkg::IDX_DIRECTION:  rd_value = {2'b00, dir_eff};
            // RULE9 RULE8 pull-up readback
            port_a_pkg::IDX_PULLUP_EN:  rd_value = {2'b00, pullup_eff};
            port_a_pkg::IDX_CHANGE_EN:  rd_value = {2'b00, change_eff};
            port_a_pkg::IDX_OPTION:     rd_value = option;
            port_a_pkg::IDX_INT_CTRL: begin
                rd_value = int_ctrl;
                rd_value[port_a_pkg::INT_CHANGE_FLAG_BIT] = change_flag;
            end
            port_a_pkg::IDX_POWER_CTRL: rd_value = power_ctrl;
            default:                    rd_value = 8'h00;
        endcase
    end

    // Read data channel
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RVALID <= 1'b0;
            RDATA  <= '0;
            RRESP  <= port_a_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            RVALID <= 1'b1;
            RDATA  <= {24'h000000, rd_value};
            RRESP  <= is_mapped(ARADDR) ? port_a_pkg::RESP_OKAY
                                        : port_a_pkg::RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // RULE14 any data register access reloads latch
    assign port_access =
        (ar_fire && is_mapped(ARADDR) && rd_idx == port_a_pkg::IDX_PIN_DATA) ||
        (wr_ok && wr_idx == port_a_pkg::IDX_PIN_DATA);

    // RULE16 latch kept through warm reset
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cmp_latch <= port_a_pkg::RST_CMP_LATCH;
        end else if (port_access) begin
            // RULE17 latch loads the current sample; a same-cycle mismatch still sets the flag
            cmp_latch <= pin_sample;
        end
    end

    // RULE12 OR of enabled mismatches
    assign mismatch = |((pin_sample ^ cmp_latch) & change_eff);

    // RULE15 set wins over software clear
    always_comb begin
        next_flag = change_flag;
        if (wr_ok && wr_idx == port_a_pkg::IDX_INT_CTRL) begin
            next_flag = wr_byte[port_a_pkg::INT_CHANGE_FLAG_BIT];
        end
        if (mismatch) begin
            next_flag = 1'b1;
        end
    end

    // RULE16 flag resets but mismatch sets it again
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            change_flag <= 1'b0;
        end else if (!WARM_RESETN) begin
            change_flag <= mismatch;
        end else begin
            change_flag <= next_flag;
        end
    end

    // RULE21 interrupt needs global enable
    assign PORT_IRQ = change_flag
                      && int_ctrl[port_a_pkg::INT_CHANGE_EN_BIT]
                      && int_ctrl[port_a_pkg::INT_GLOBAL_EN_BIT];

    // RULE13 wake condition from change interrupt
    assign wake_cond = change_flag && int_ctrl[port_a_pkg::INT_CHANGE_EN_BIT];

    // RULE13 RULE19 RULE20 sleep, wake pulse and vector choice
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SLEEPING       <= 1'b0;
            WAKE           <= 1'b0;
            WAKE_TO_VECTOR <= 1'b0;
        end else if (!WARM_RESETN) begin
            SLEEPING       <= 1'b0;
            WAKE           <= 1'b0;
            WAKE_TO_VECTOR <= 1'b0;
        end else if (SLEEPING && wake_cond) begin
            SLEEPING       <= 1'b0;
            WAKE           <= 1'b1;
            WAKE_TO_VECTOR <= int_ctrl[port_a_pkg::INT_GLOBAL_EN_BIT];
        end else begin
            SLEEPING       <= SLEEPING || (SLEEP_ENTER && !wake_cond);
            WAKE           <= 1'b0;
            WAKE_TO_VECTOR <= 1'b0;
        end
    end

endmodule : port_a_gpio

// ### dv/port_a_checker.sv
// Port A checker: pull-up, read and wake relations seen at the block ports
`timescale 1ns/1ps
module port_a_checker #(
    parameter int ADDR_W = 10,
    parameter int PINS   = 6
) (
    input wire logic              REF_CLK,
    input wire logic              RESETN,
    input wire logic              WARM_RESETN,
    input wire logic              AWVALID,
    input wire logic              WVALID,
    input wire logic              BVALID,
    input wire logic              BREADY,
    input wire logic [1:0]        BRESP,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic              ARVALID,
    input wire logic              ARREADY,
    input wire logic [31:0]       RDATA,
    input wire logic [1:0]        RRESP,
    input wire logic              RVALID,
    input wire logic              RREADY,
    input wire logic [PINS-1:0]   PIN_OE,
    input wire logic [PINS-1:0]   PULLUP_ON,
    input wire logic              CLEAR_PIN_SELECT,
    input wire logic              SLEEPING,
    input wire logic              WAKE,
    input wire logic              WAKE_TO_VECTOR,
    input wire logic              PORT_IRQ
);
    logic [ADDR_W-1:0] rd_addr;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // Address of the read in flight
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_addr <= '0;
        end else if (ARVALID && ARREADY) begin
            rd_addr <= ARADDR;
        end
    end

    AST_PULLUP_OUTPUT: assert property ((PIN_OE & PULLUP_ON) == '0)
        else $error("pull-up on for a driven pin");
    AST_PIN3_PULLUP: assert property (PULLUP_ON[3] == CLEAR_PIN_SELECT)
        else $error("pin three pull-up does not follow clear select");
    AST_PIN3_INPUT: assert property (!PIN_OE[3])
        else $error("pin three driven");
    AST_DATA_TOP: assert property (RVALID && rd_addr == {port_a_pkg::IDX_PIN_DATA, 2'b00}
        |-> RDATA[31:6] == '0)
        else $error("data read upper bits not zero");
    AST_READ_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_READ_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
    AST_WRITE_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before taken");
    AST_SLVERR_ZERO: assert property (RVALID && RRESP == port_a_pkg::RESP_SLVERR
        |-> RDATA == '0)
        else $error("error read carries data");
    AST_WAKE_VECTOR: assert property (WAKE_TO_VECTOR |-> WAKE)
        else $error("vector without wake");
    AST_WAKE_FROM_SLEEP: assert property (WAKE |-> !SLEEPING && $past(SLEEPING))
        else $error("wake without sleep ending");
    AST_IRQ_HOLD: assert property (PORT_IRQ && !AWVALID && !WVALID && WARM_RESETN
        |=> PORT_IRQ)
        else $error("change request dropped without software");

    // Main scenarios
    COV_WAKE_VECTOR: cover property (WAKE && WAKE_TO_VECTOR);
    COV_SLVERR: cover property (RVALID && RRESP == port_a_pkg::RESP_SLVERR);
    COV_IRQ: cover property (PORT_IRQ);
endmodule : port_a_checker

bind port_a_gpio port_a_checker #(.ADDR_W(ADDR_W), .PINS(PINS)) chk (.*);

// ### dv/pin_side.sv
// Far-side pin model: external drivers, pull-ups and the wake capacitor
`timescale 1ns/1ps
module pin_side #(
    parameter int DISCHARGE = 40
) (
    input  wire logic       clk,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pullup_on,
    input  wire logic       sink_on,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic [5:0]      level
);
    int         charge = 0;
    logic [5:0] last   = 6'h00;

    always_ff @(posedge clk) begin
        if (pin_oe[0] && pin_out[0]) begin
            charge <= DISCHARGE;
        end else if (sink_on && charge > 0) begin
            charge <= charge - 1;
        end
        last <= level;
    end

    // Driver first, then outside source, pull-up, capacitor, else floating
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe[i]) level[i] = pin_out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pullup_on[i]) level[i] = 1'b1;
            else if (i == 0) level[i] = (charge > 0);
            else level[i] = ~last[i];
        end
    end
endmodule : pin_side

// ### dv/tb.sv
// Register and pin level bench for the port A block
`timescale 1ns/1ps
module tb;
    logic        REF_CLK = 1'b0, RESETN = 1'b0, WARM_RESETN = 1'b1;
    logic [9:0]  AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0;
    logic [3:0]  WSTRB = 4'h1;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        CLEAR_PIN_SELECT = 1'b1, CRYSTAL_MODE = 1'b0, SLEEP_ENTER = 1'b0;
    logic [5:0]  ext_en = 6'h3f, ext_val = 6'h2a;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, ULP_SINK_ON, SLEEPING, WAKE;
    logic        WAKE_TO_VECTOR, PORT_IRQ;
    logic [1:0]  BRESP, RRESP, resp;
    logic [31:0] RDATA, rdat;
    logic [5:0]  PIN_IN, PIN_OUT, PIN_OE, PULLUP_ON;
    int          failures = 0, n_checks = 0;

    port_a_gpio dut (.*);
    pin_side pins (.clk(REF_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pullup_on(PULLUP_ON),
        .sink_on(ULP_SINK_ON), .ext_en(ext_en), .ext_val(ext_val), .level(PIN_IN));

    // Clock at 50 ns period
    always #25 REF_CLK = ~REF_CLK;

    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Write: address and data offered together, response awaited
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic a, w, b;
        b = 1'b0;
        @(posedge REF_CLK);
        AWADDR <= {idx, 2'b00};
        WDATA <= {24'h0, val};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge REF_CLK);
            a = AWVALID && (AWREADY === 1'b1);
            w = WVALID && (WREADY === 1'b1);
            b = (BVALID === 1'b1);
            resp = BRESP;
            @(posedge REF_CLK);
            if (a) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        if (!b) begin
            check(32'h0, 32'h1);
            complete_run();
        end
    endtask : wr

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] idx);
        logic a, got;
        got = 1'b0;
        @(posedge REF_CLK);
        ARADDR <= {idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(negedge REF_CLK);
            a = ARVALID && (ARREADY === 1'b1);
            got = (RVALID === 1'b1);
            rdat = RDATA;
            resp = RRESP;
            @(posedge REF_CLK);
            if (a) ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        if (!got) begin
            check(32'h0, 32'h1);
            complete_run();
        end
    endtask : rd

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        check(rdat, {24'h0, exp});
    endtask : rd_chk

    // Main sequence
    initial begin
        repeat (3) @(posedge REF_CLK);
        RESETN <= 1'b1;
        rd_chk(port_a_pkg::IDX_DIRECTION, 8'h3f);
        rd_chk(port_a_pkg::IDX_PULLUP_EN, 8'h37);
        rd_chk(port_a_pkg::IDX_CHANGE_EN, 8'h00);
        rd_chk(port_a_pkg::IDX_OPTION, 8'hff);
        check({26'h0, PULLUP_ON}, 32'h08);
        wr(8'h40, 8'hff);
        check({30'h0, resp}, {30'h0, port_a_pkg::RESP_SLVERR});
        $display("test reset_values finished");
        wr(port_a_pkg::IDX_DIRECTION, 8'h00);
        rd_chk(port_a_pkg::IDX_DIRECTION, 8'h08);
        wr(port_a_pkg::IDX_PIN_DATA, 8'h15);
        @(negedge REF_CLK);
        check({26'h0, PIN_OE}, 32'h37);
        check({26'h0, PIN_OUT}, 32'h15);
        rd_chk(port_a_pkg::IDX_PIN_DATA, 8'h15);
        CLEAR_PIN_SELECT <= 1'b0;
        wr(port_a_pkg::IDX_DIRECTION, 8'h3f);
        rd_chk(port_a_pkg::IDX_PIN_DATA, 8'h2a);
        $display("test direction_data finished");
        wr(port_a_pkg::IDX_OPTION, 8'h7f);
        wr(port_a_pkg::IDX_DIRECTION, 8'h3e);
        @(negedge REF_CLK);
        check({26'h0, PULLUP_ON}, 32'h36);
        wr(port_a_pkg::IDX_PULLUP_EN, 8'hff);
        rd_chk(port_a_pkg::IDX_PULLUP_EN, 8'h37);
        wr(port_a_pkg::IDX_PULLUP_EN, 8'h05);
        @(negedge REF_CLK);
        check({26'h0, PULLUP_ON}, 32'h04);
        wr(port_a_pkg::IDX_OPTION, 8'hff);
        @(negedge REF_CLK);
        check({26'h0, PULLUP_ON}, 32'h00);
        $display("test pullups finished");
        @(posedge REF_CLK);
        CRYSTAL_MODE <= 1'b1;
        ext_val <= 6'h3f;
        wr(port_a_pkg::IDX_DIRECTION, 8'h00);
        rd_chk(port_a_pkg::IDX_DIRECTION, 8'h38);
        rd_chk(port_a_pkg::IDX_PULLUP_EN, 8'h35);
        rd_chk(port_a_pkg::IDX_CHANGE_EN, 8'h30);
        rd_chk(port_a_pkg::IDX_PIN_DATA, 8'h3d);
        WARM_RESETN <= 1'b0;
        @(posedge REF_CLK);
        WARM_RESETN <= 1'b1;
        rd_chk(port_a_pkg::IDX_INT_CTRL, 8'h00);
        ext_val <= 6'h0f;
        @(posedge REF_CLK);
        rd_chk(port_a_pkg::IDX_INT_CTRL, 8'h01);
        CRYSTAL_MODE <= 1'b0;
        rd(port_a_pkg::IDX_PIN_DATA);
        wr(port_a_pkg::IDX_INT_CTRL, 8'h00);
        rd_chk(port_a_pkg::IDX_INT_CTRL, 8'h00);
        $display("test crystal_warm_reset finished");
        wr(port_a_pkg::IDX_CHANGE_EN, 8'h02);
        rd(port_a_pkg::IDX_PIN_DATA);
        ext_val <= 6'h0d;
        wr(port_a_pkg::IDX_INT_CTRL, 8'h88);
        rd_chk(port_a_pkg::IDX_INT_CTRL, 8'h89);
        check({31'h0, PORT_IRQ}, 32'h1);
        rd_chk(port_a_pkg::IDX_PIN_DATA, 8'h0d);
        wr(port_a_pkg::IDX_INT_CTRL, 8'h88);
        ext_val <= 6'h09;
        rd_chk(port_a_pkg::IDX_INT_CTRL, 8'h88);
        wr(port_a_pkg::IDX_INT_CTRL, 8'h09);
        @(negedge REF_CLK);
        check({31'h0, PORT_IRQ}, 32'h0);
        wr(port_a_pkg::IDX_INT_CTRL, 8'h08);
        $display("test change_flag finished");
        // latch one, enable change, drive to charge, input, sink, sleep
        wr(port_a_pkg::IDX_PIN_DATA, 8'h01);
        wr(port_a_pkg::IDX_CHANGE_EN, 8'h01);
        wr(port_a_pkg::IDX_DIRECTION, 8'h3e);
        ext_en <= 6'h3e;
        wr(port_a_pkg::IDX_DIRECTION, 8'h3f);
        rd(port_a_pkg::IDX_PIN_DATA);
        wr(port_a_pkg::IDX_POWER_CTRL, 8'h20);
        @(negedge REF_CLK);
        check({31'h0, ULP_SINK_ON}, 32'h1);
        wr(port_a_pkg::IDX_INT_CTRL, 8'h88);
        SLEEP_ENTER <= 1'b1;
        @(posedge REF_CLK);
        SLEEP_ENTER <= 1'b0;
        for (int n = 0; n < 200 && WAKE !== 1'b1; n++) @(negedge REF_CLK);
        check({31'h0, WAKE}, 32'h1);
        check({31'h0, WAKE_TO_VECTOR}, 32'h1);
        check({31'h0, SLEEPING}, 32'h0);
        $display("test low_power_wake finished");
        complete_run();
    end
endmodule : tb
